// ### design/acu_capture.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1 - msb-first: left start bit goes to bit 15, downward to stop index, rest cleared
// R2 - lsb-first: left start bit goes to stop index, upward to bit 15, low bits cleared
// R3 - right word built the same way from its own start position
// R4 - captured bits always left-adjusted in a 16-bit word
// R5 - samples written to memory autonomously, mono or stereo, 8 or 16 bits
// R6 - each sample stored at a higher address than the previous one
// R7 - byte order 0 big-endian (reset), 1 little-endian
// R8 - software gives both buffers 64-byte aligned bases; bases reset to zero
// R9 - switch buffer after programmed sample count; pair or mono value is one sample
// R10 - format 00 mono8, 01 stereo8, 10 mono16, 11 stereo16; reset 00
// R11 - 8-bit formats store only the eight top bits of each word
// R12 - 16-bit formats store the whole word
// R13 - sign conversion setting 1 inverts the stored msb
// R14 - no companded output; only linear data is stored
// R15 - host sets base and count before capture starts
// R16 - stereo stores left then right consecutively; mono stores left only
// R17 - start positions name the frame bit of each channel's first bit; reset zero
// R18 - bit order 0 msb-first (reset), 1 lsb-first
// R19 - stop index 0..15 marks where captured data ends or begins
// R20 - after reset the first sample goes to buffer one, marked current
module acu_capture #(
    parameter int FRAME_W = 9
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // serial link from converter
    input  wire logic        sck_i,
    input  wire logic        ws_i,
    input  wire logic        sd_i,
    // memory write port
    output logic             mem_we_o,
    output logic      [31:0] mem_adr_o,
    output logic      [15:0] mem_dat_o,
    output logic      [1:0]  mem_be_o,
    input  wire logic        mem_rdy_i
);
    import acu_pkg::*;

    // start fields must fit below the right field's position
    if (FRAME_W < 6 || FRAME_W > 12) begin : g_frame_w_check
        $error("FRAME_W out of range");
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] frame_r;
    logic [31:0] first_buffer_base_r;
    logic [31:0] second_buffer_base_r;
    logic [31:0] count_r;
    logic [31:0] wr_mask;
    logic [31:0] ctrl_nxt;
    logic [31:0] frame_nxt;
    logic [31:0] first_buffer_base_mrg;
    logic [31:0] second_buffer_base_mrg;
    logic [31:0] first_buffer_base_nxt;
    logic [31:0] second_buffer_base_nxt;
    logic [31:0] count_nxt;
    logic        wb_req;
    logic        wb_wr;

    // registered ack: a request is taken once, then masked by its own ack
    assign wb_req  = cyc_i && stb_i && !ack_o;
    assign wb_wr   = wb_req && we_i;
    assign wr_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    function automatic logic [31:0] acu_merge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [31:0] m);
        acu_merge = (old & ~m) | (d & m);
    endfunction : acu_merge

    assign ctrl_nxt  = acu_merge(ctrl_r, dat_i, wr_mask);
    assign frame_nxt = acu_merge(frame_r, dat_i, wr_mask);
    assign first_buffer_base_mrg = acu_merge(first_buffer_base_r, dat_i, wr_mask);
    assign second_buffer_base_mrg = acu_merge(second_buffer_base_r, dat_i, wr_mask);
    // low six bits forced to zero: 64-byte alignment    // see R8
    assign first_buffer_base_nxt = {first_buffer_base_mrg[31:6], ACU_ALIGN_ZERO};
    assign second_buffer_base_nxt = {second_buffer_base_mrg[31:6], ACU_ALIGN_ZERO};
    assign count_nxt = acu_merge(count_r, dat_i, wr_mask);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r  <= ACU_CTRL_RST;                       // see R10 see R13 see R18
            frame_r <= ACU_FRAME_RST;                      // see R17
            first_buffer_base_r <= ACU_BASE_RST;                       // see R8
            second_buffer_base_r <= ACU_BASE_RST;
            count_r <= ACU_COUNT_RST;                      // see R9
        end else if (wb_wr) begin
            if (adr_i == ACU_CTRL_ADR)  ctrl_r  <= ctrl_nxt;
            if (adr_i == ACU_FRAME_ADR) frame_r <= frame_nxt;
            if (adr_i == ACU_FIRST_BUFFER_BASE_ADR) first_buffer_base_r <= first_buffer_base_nxt;
            if (adr_i == ACU_SECOND_BUFFER_BASE_ADR) second_buffer_base_r <= second_buffer_base_nxt;
            if (adr_i == ACU_COUNT_ADR) count_r <= count_nxt; // see R15
        end
    end

    wire         cap_en    = ctrl_r[ACU_CTL_EN];
    wire  [1:0]  fmt       = ctrl_r[ACU_CTL_MODE +: 2];
    wire         sign_cv   = ctrl_r[ACU_CTL_SIGN];
    wire         little_en = ctrl_r[ACU_CTL_LE];
    wire         lsb_first = ctrl_r[ACU_CTL_ORDER];                    // see R18
    wire  [3:0]  stop_idx  = ctrl_r[ACU_CTL_STOP +: 4];
    wire  [FRAME_W-1:0] left_pos  = frame_r[ACU_FRM_LEFT +: FRAME_W];
    wire  [FRAME_W-1:0] right_pos = frame_r[ACU_FRM_RIGHT +: FRAME_W];
    wire         stereo    = fmt[0];                                   // see R10
    wire         wide      = fmt[1];

    // ----------------------------------------
    // serial input sampling
    // ----------------------------------------
    // sck is slow against clk_i, so edges are found by oversampling
    logic [1:0] sck_s_r;
    logic [1:0] ws_s_r;
    logic [1:0] sd_s_r;
    logic       sck_d_r;
    logic       ws_d_r;
    wire        sck_rise;
    wire        frame_start;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_s_r <= 2'h0;
            ws_s_r  <= 2'h0;
            sd_s_r  <= 2'h0;
            sck_d_r <= 1'h0;
            // ws idles high between frames; a low reset value would hide the first frame
            ws_d_r  <= 1'h1;
        end else begin
            sck_s_r <= {sck_s_r[0], sck_i};
            ws_s_r  <= {ws_s_r[0], ws_i};
            sd_s_r  <= {sd_s_r[0], sd_i};
            sck_d_r <= sck_s_r[1];
            if (sck_rise) ws_d_r <= ws_s_r[1];
        end
    end
    assign sck_rise    = sck_s_r[1] && !sck_d_r;
    // frame opens on falling ws seen at an sck rise; next edge is bit 0
    assign frame_start = sck_rise && ws_d_r && !ws_s_r[1];

    // ----------------------------------------
    // serial-to-parallel assembly
    // ----------------------------------------
    logic [FRAME_W-1:0] bitpos_r;
    logic               in_frame_r;
    logic [15:0]        left_r;
    logic [15:0]        right_r;
    logic               word_rdy_r;
    logic [15:0]        left_hold_r;
    logic [15:0]        right_hold_r;

    // number of bits to capture: 16 - stop index
    wire  [4:0] nbits = 5'h10 - {1'h0, stop_idx};                      // see R19
    wire        l_act = in_frame_r && (bitpos_r >= left_pos) &&
                        (bitpos_r - left_pos < FRAME_W'(nbits));        // see R17
    wire        r_act = in_frame_r && (bitpos_r >= right_pos) &&
                        (bitpos_r - right_pos < FRAME_W'(nbits));       // see R3
    wire  [3:0] l_idx = 4'(bitpos_r - left_pos);
    wire  [3:0] r_idx = 4'(bitpos_r - right_pos);
    // msb-first fills 15 downward, lsb-first fills stop index upward
    wire  [3:0] l_bit = lsb_first ? 4'(stop_idx + l_idx) : 4'(4'hF - l_idx);  // see R1 see R2
    wire  [3:0] r_bit = lsb_first ? 4'(stop_idx + r_idx) : 4'(4'hF - r_idx);  // see R3
    wire        bit_edge = sck_rise && !frame_start;
    wire  [FRAME_W-1:0] pos_max = '1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bitpos_r   <= '0;
            in_frame_r <= 1'h0;
            left_r     <= 16'h0000;
            right_r    <= 16'h0000;
            word_rdy_r <= 1'h0;
            left_hold_r  <= 16'h0000;
            right_hold_r <= 16'h0000;
        end else begin
            word_rdy_r <= 1'h0;
            if (frame_start) begin
                // finished frame hands over its words, bits below stop stay zero
                if (in_frame_r) begin
                    left_hold_r  <= left_r;                               // see R4
                    right_hold_r <= right_r;
                    word_rdy_r   <= cap_en;
                end
                in_frame_r <= 1'h1;
                bitpos_r   <= '0;
                left_r     <= 16'h0000;                                   // see R1 see R2
                right_r    <= 16'h0000;
            end else if (bit_edge && in_frame_r) begin
                if (l_act) left_r[l_bit]  <= sd_s_r[1];
                if (r_act) right_r[r_bit] <= sd_s_r[1];
                if (bitpos_r != pos_max) bitpos_r <= bitpos_r + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // memory packing
    // ----------------------------------------
    // a stalled write holds every field; nothing is buffered behind it
    acu_wr_t     st_r;
    logic        buf1_cur_r;
    logic [31:0] offs_r;
    logic [31:0] smp_cnt_r;
    logic [15:0] cur_word;
    logic [15:0] conv;
    logic [15:0] data16;
    logic        odd;

    assign cur_word = (st_r == ACU_RIGHT) ? right_hold_r : left_hold_r;  // see R16
    // no companding path; linear data only                                // see R14
    assign conv     = {cur_word[15] ^ sign_cv, cur_word[14:0]};            // see R13
    assign odd      = offs_r[0];
    // narrow words keep the top byte, placed in the lane of its address
    assign data16   = wide ? (little_en ? {conv[7:0], conv[15:8]} : conv)  // see R12 see R7
                           : {conv[15:8], conv[15:8]};                     // see R11
    wire   [1:0] be8 = (odd ^ little_en) ? 2'h1 : 2'h2;                    // see R7
    wire  [31:0] base = buf1_cur_r ? first_buffer_base_r : second_buffer_base_r;
    wire  [31:0] step = wide ? 32'h2 : 32'h1;
    wire  [31:0] wr_adr = base + offs_r;                                 // see R6
    wire  [31:0] offs_step = offs_r + step;
    wire   [1:0] be_sel = wide ? 2'h3 : be8;
    // count 0 acts as 1: every sample switches buffers
    wire         last_smp = (smp_cnt_r + 32'h1) >= count_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r       <= ACU_IDLE;
            buf1_cur_r <= 1'h1;                                          // see R20
            offs_r     <= 32'h0;
            smp_cnt_r  <= 32'h0;
            mem_we_o   <= 1'h0;
            mem_adr_o  <= 32'h0;
            mem_dat_o  <= 16'h0000;
            mem_be_o   <= 2'h0;
        end else begin
            case (st_r)
                ACU_IDLE: begin
                    if (word_rdy_r) st_r <= ACU_LEFT;                    // see R5
                end
                ACU_LEFT, ACU_RIGHT: begin
                    if (!mem_we_o) begin
                        mem_we_o  <= 1'h1;
                        mem_adr_o <= wr_adr;                             // see R6
                        mem_dat_o <= data16;
                        mem_be_o  <= be_sel;
                    end else if (mem_rdy_i) begin
                        mem_we_o <= 1'h0;
                        offs_r   <= offs_step;                           // see R6
                        if (st_r == ACU_LEFT && stereo) st_r <= ACU_RIGHT; // see R16 see R10
                        else st_r <= ACU_DONE;
                    end
                end
                ACU_DONE: begin
                    st_r <= ACU_IDLE;
                    if (last_smp) begin                                  // see R9
                        buf1_cur_r <= !buf1_cur_r;
                        smp_cnt_r  <= 32'h0;
                        offs_r     <= 32'h0;
                    end else begin
                        smp_cnt_r <= smp_cnt_r + 32'h1;
                    end
                end
                default: st_r <= ACU_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    wire [31:0] status = {29'h0, st_r != ACU_IDLE, in_frame_r, buf1_cur_r};
    logic [31:0] rd_mux;
    always_comb begin
        case (adr_i)
            ACU_CTRL_ADR:   rd_mux = ctrl_r;
            ACU_FRAME_ADR:  rd_mux = frame_r;
            ACU_FIRST_BUFFER_BASE_ADR:  rd_mux = first_buffer_base_r;
            ACU_SECOND_BUFFER_BASE_ADR:  rd_mux = second_buffer_base_r;
            ACU_COUNT_ADR:  rd_mux = count_r;
            ACU_STATUS_ADR: rd_mux = status;
            default:        rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'h0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= wb_req;
            dat_o <= wb_req ? rd_mux : 32'h0;
        end
    end
endmodule : acu_capture
`default_nettype wire

// ### design/acu_pkg.sv
package acu_pkg;
    // register byte offsets
    localparam logic [7:0] ACU_CTRL_ADR   = 8'h00;
    localparam logic [7:0] ACU_FRAME_ADR  = 8'h04;
    localparam logic [7:0] ACU_FIRST_BUFFER_BASE_ADR  = 8'h08;
    localparam logic [7:0] ACU_SECOND_BUFFER_BASE_ADR  = 8'h0C;
    localparam logic [7:0] ACU_COUNT_ADR  = 8'h10;
    localparam logic [7:0] ACU_STATUS_ADR = 8'h14;
    // control field positions
    localparam int ACU_CTL_EN    = 0;
    localparam int ACU_CTL_MODE  = 1;
    localparam int ACU_CTL_SIGN  = 3;
    localparam int ACU_CTL_LE    = 4;
    localparam int ACU_CTL_ORDER = 5;
    localparam int ACU_CTL_STOP  = 8;
    // frame field positions
    localparam int ACU_FRM_LEFT  = 0;
    localparam int ACU_FRM_RIGHT = 16;
    // reset values
    localparam logic [31:0] ACU_CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] ACU_FRAME_RST = 32'h0000_0000;
    localparam logic [31:0] ACU_BASE_RST  = 32'h0000_0000;
    localparam logic [31:0] ACU_COUNT_RST = 32'h0000_0000;
    localparam logic [5:0]  ACU_ALIGN_ZERO = 6'h00;
    // capture formats
    localparam logic [1:0] ACU_FMT_MONO8    = 2'h0;
    localparam logic [1:0] ACU_FMT_STEREO8  = 2'h1;
    localparam logic [1:0] ACU_FMT_MONO16   = 2'h2;
    localparam logic [1:0] ACU_FMT_STEREO16 = 2'h3;
    localparam int ACU_WORD_W = 16;
    typedef enum logic [1:0] {ACU_IDLE, ACU_LEFT, ACU_RIGHT, ACU_DONE} acu_wr_t;
endpackage : acu_pkg

// ### sim/acu_capture_chk.sv
`timescale 1ns/1ns
`default_nettype none
module acu_capture_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    input wire logic        mem_we_o,
    input wire logic [31:0] mem_adr_o,
    input wire logic [15:0] mem_dat_o,
    input wire logic [1:0]  mem_be_o,
    input wire logic        mem_rdy_i
);
    import acu_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // shadow of the low control bits, taken at the same edge as the design
    logic [4:0] ctl_r;
    wire        wide = ctl_r[ACU_CTL_MODE + 1];
    wire        le   = ctl_r[ACU_CTL_LE];
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ctl_r <= 5'h00;
        else if (cyc_i && stb_i && we_i && !ack_o && adr_i == ACU_CTRL_ADR && sel_i[0])
            ctl_r <= dat_i[4:0];
    end
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_write_held: assert property (mem_we_o && !mem_rdy_i |=> mem_we_o && $stable(mem_adr_o)
        && $stable(mem_dat_o) && $stable(mem_be_o)) else $error("write request dropped");
    a_write_ends: assert property (mem_we_o && mem_rdy_i |=> !mem_we_o) else $error("write kept");
    a_wide_lanes: assert property (mem_we_o && wide |-> mem_be_o == 2'h3 && !mem_adr_o[0])
        else $error("wide write lanes wrong");
    a_byte_dup: assert property (mem_we_o && !wide |-> mem_dat_o[15:8] == mem_dat_o[7:0])
        else $error("byte not on both lanes");
    a_big_lane: assert property (mem_we_o && !wide && !le |-> mem_be_o == (mem_adr_o[0] ? 2'h1 : 2'h2))
        else $error("big endian lane wrong");
    a_little_lane: assert property (mem_we_o && !wide && le |-> mem_be_o == (mem_adr_o[0] ? 2'h2 : 2'h1))
        else $error("little endian lane wrong");
endmodule : acu_capture_chk
bind acu_capture acu_capture_chk u_acu_capture_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .ack_o, .mem_we_o, .mem_adr_o, .mem_dat_o, .mem_be_o, .mem_rdy_i);
`default_nettype wire

// ### sim/acu_adc_model.sv
`timescale 1ns/1ns
`default_nettype none
module acu_adc_model (
    output logic sck_o,
    output logic ws_o,
    output logic sd_o
);
    initial begin
        sck_o = 1'b0;
        ws_o = 1'b1;
        sd_o = 1'b0;
    end
    // clock runs only inside a frame; odd offset keeps it off the system clock edges
    task automatic send_frame(input logic [39:0] bits);
        #7;
        ws_o = 1'b0;
        #160;
        sck_o = 1'b1;
        #160;
        for (int i = 0; i < 40; i++) begin
            sck_o = 1'b0;
            sd_o = bits[i];
            if (i == 20)
                ws_o = 1'b1;
            #160;
            sck_o = 1'b1;
            #160;
        end
        sck_o = 1'b0;
        sd_o = ~sd_o;
        #320;
    endtask : send_frame
endmodule : acu_adc_model
`default_nettype wire

// ### sim/tb_acu_capture.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_acu_capture;
    import acu_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, mem_rdy_i = 0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, mem_adr_o, rd;
    logic        ack_o, mem_we_o, sck, ws, sd;
    logic [15:0] mem_dat_o;
    logic [1:0]  mem_be_o;
    logic [49:0] got_q[$], exp_q[$];
    int          n_fail = 0, checked = 0, cyc_n = 0, fmt, sgn, le, lsb, stop, lpos, rpos;
    // fmt, sign, little endian, lsb first, stop index, left start, right start
    int          cfg[4][7] = '{'{0, 1, 0, 0, 0, 3, 0}, '{1, 0, 1, 1, 4, 1, 20},
                               '{2, 0, 1, 0, 15, 5, 0}, '{3, 1, 0, 1, 0, 0, 24}};
    always #20 clk_i = ~clk_i;
    // memory stalls one cycle in three
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        mem_rdy_i <= (cyc_n % 3) != 0;
        if (mem_we_o && mem_rdy_i)
            got_q.push_back({mem_adr_o, mem_dat_o, mem_be_o});
    end
    acu_capture #(.FRAME_W(9)) u_acu_capture (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .sck_i(sck), .ws_i(ws), .sd_i(sd), .mem_we_o, .mem_adr_o, .mem_dat_o, .mem_be_o, .mem_rdy_i);
    acu_adc_model u_acu_adc_model (.sck_o(sck), .ws_o(ws), .sd_o(sd));
    // waits for ack however long it takes; only the watchdog ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'hF};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'h0;
    endtask : wb
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : do_reset
    function automatic logic [15:0] pack_word(input logic [39:0] f, input int st);
        logic [15:0] w;
        w = 16'h0000;
        for (int i = 0; i < 16 - stop; i++) begin
            if (lsb)
                w[stop + i] = f[st + i];
            else
                w[15 - i] = f[st + i];
        end
        return w;
    endfunction : pack_word
    task automatic expect_sample(input logic [39:0] f, input logic [31:0] base, inout int off);
        logic [15:0] w;
        for (int ch = 0; ch <= fmt[0]; ch++) begin
            w = pack_word(f, ch ? rpos : lpos);
            w[15] ^= sgn[0];
            if (fmt[1]) begin
                exp_q.push_back({base + off, le ? {w[7:0], w[15:8]} : w, 2'h3});
                off += 2;
            end else begin
                exp_q.push_back({base + off, w[15:8], w[15:8], (le[0] ^ off[0]) ? 2'h1 : 2'h2});
                off += 1;
            end
        end
    endtask : expect_sample
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [39:0] pat, fr;
        int          off;
        pat = 40'h9C_5A3F_E1B7;
        do_reset();
        for (int a = 0; a <= 24; a += 4) begin
            wb(1'b0, a[7:0], 32'h0);
            `CHK(rd, (a == 20) ? 32'h0000_0001 : 32'h0000_0000)
        end
        wb(1'b1, ACU_FIRST_BUFFER_BASE_ADR, 32'hFFFF_FFFF);
        wb(1'b0, ACU_FIRST_BUFFER_BASE_ADR, 32'h0);
        `CHK(rd, 32'hFFFF_FFC0)
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            {fmt, sgn, le, lsb, stop, lpos, rpos} = {cfg[c][0], cfg[c][1], cfg[c][2], cfg[c][3], cfg[c][4],
                cfg[c][5], cfg[c][6]};
            do_reset();
            got_q.delete();
            exp_q.delete();
            wb(1'b1, ACU_FIRST_BUFFER_BASE_ADR, 32'h0000_0100);
            wb(1'b1, ACU_SECOND_BUFFER_BASE_ADR, 32'h0000_0240);
            wb(1'b1, ACU_COUNT_ADR, 32'h0000_0002);
            wb(1'b1, ACU_FRAME_ADR, (rpos << ACU_FRM_RIGHT) | (lpos << ACU_FRM_LEFT));
            wb(1'b1, ACU_CTRL_ADR, 1 | (fmt << ACU_CTL_MODE) | (sgn << ACU_CTL_SIGN) | (le << ACU_CTL_LE)
                | (lsb << ACU_CTL_ORDER) | (stop << ACU_CTL_STOP));
            off = 0;
            // the last frame only closes the one before; each frame is handed over when the next one starts
            for (int k = 0; k < 4; k++) begin
                fr = (pat << (k * 7)) | (pat >> (40 - k * 7));
                u_acu_adc_model.send_frame(fr);
                if (k == 2)
                    off = 0;
                if (k < 3)
                    expect_sample(fr, (k < 2) ? 32'h0000_0100 : 32'h0000_0240, off);
            end
            repeat (40) @(posedge clk_i);
            `CHK(got_q.size(), exp_q.size())
            foreach (exp_q[i])
                `CHK(got_q[i], exp_q[i])
            wb(1'b0, ACU_STATUS_ADR, 32'h0);
            `CHK(rd[0], 1'b0)
            $display("test format %0d done", c);
        end
        summarize();
    end
    // about four times the expected run length
    initial begin
        #1000000;
        n_fail++;
        summarize();
    end
endmodule : tb_acu_capture
`default_nettype wire
